// [src/nst_consts.svh]
// constants of the network module self-test sequencer
`ifndef NST_CONSTS_SVH
`define NST_CONSTS_SVH
`define NST_CMD_DIAG      8'h12
`define NST_CMD_RESET     8'h77
`define NST_RES_PASS      8'h00
`define NST_RES_CHKSUM    8'h01
`define NST_RES_MEM       8'h02
`define NST_RES_ADDR      8'h03
`define NST_RES_LOOP      8'h04
`define NST_PAT0          8'h00
`define NST_PAT1          8'hFF
`define NST_PAT2          8'h55
`define NST_PAT3          8'hAA
`define NST_RES_RST       8'h00
`endif

// [src/nst_pkg.sv]
// types of the network module self-test sequencer
package nst_pkg;
    typedef enum logic [3:0] {
        NST_IDLE    = 4'b0000,
        NST_OFFLINE = 4'b0001,
        NST_CHKSUM  = 4'b0010,
        NST_CHKWAIT = 4'b0011,
        NST_MEMWR   = 4'b0100,
        NST_MEMRD   = 4'b0101,
        NST_ADDR    = 4'b0110,
        NST_INIT    = 4'b0111,
        NST_LOOP    = 4'b1000,
        NST_LOOPW   = 4'b1001,
        NST_BRDRST  = 4'b1010,
        NST_LED     = 4'b1011,
        NST_REPORT  = 4'b1100
    } nst_state_e;
    typedef enum logic [1:0] {
        NST_MEM_WORK = 2'b00,
        NST_MEM_BUF  = 2'b01
    } nst_mem_e;
endpackage : nst_pkg

// [src/nst_memtest.sv]
// four-pattern write/read-back memory tester
`timescale 1ns/1ps
`default_nettype none
`include "nst_consts.svh"
module nst_memtest
    import nst_pkg::*;
#(
    parameter int AW = 4
)(
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          start,
    output logic               busy,
    output logic               done,
    output logic               fail,
    output logic               mem_we,
    output logic [AW-1:0]      mem_addr,
    output logic [7:0]         mem_wdata,
    input  wire logic [7:0]    mem_rdata
);
    // ----------------------------------------
    // pattern sweep
    // ----------------------------------------
    logic [1:0]    pat_ff, nxt_pat;
    logic [AW-1:0] adr_ff, nxt_adr;
    logic [1:0]    ph_ff, nxt_ph;   // 0 idle 1 write 2 read
    logic          done_ff, nxt_done, fail_ff, nxt_fail;
    logic [7:0]    pat;

    always_comb
    begin
        unique case (pat_ff)
            2'd0: pat = `NST_PAT0;
            2'd1: pat = `NST_PAT1;
            2'd2: pat = `NST_PAT2;
            default: pat = `NST_PAT3;
        endcase
    end

    // read data is combinational from the memory at mem_addr
    always_comb
    begin
        nxt_pat  = pat_ff;
        nxt_adr  = adr_ff;
        nxt_ph   = ph_ff;
        nxt_done = 1'b0;
        nxt_fail = fail_ff;
        if (ph_ff == 2'd0)
        begin
            if (start)
            begin
                nxt_ph   = 2'd1;
                nxt_pat  = 2'd0;
                nxt_adr  = '0;
                nxt_fail = 1'b0;
            end
        end
        else
        begin
            nxt_adr = adr_ff + 1'b1;
            if (ph_ff == 2'd2 && mem_rdata != pat)
            begin
                nxt_fail = 1'b1;
                nxt_done = 1'b1;
                nxt_ph   = 2'd0;
            end
            else if (adr_ff == {AW{1'b1}})
            begin
                if (ph_ff == 2'd1)
                    nxt_ph = 2'd2;
                else if (pat_ff == 2'd3)
                begin
                    nxt_done = 1'b1;
                    nxt_ph   = 2'd0;
                end
                else
                begin
                    nxt_ph  = 2'd1;
                    nxt_pat = pat_ff + 2'd1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pat_ff  <= 2'd0;
            adr_ff  <= '0;
            ph_ff   <= 2'd0;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
        end
        else
        begin
            pat_ff  <= nxt_pat;
            adr_ff  <= nxt_adr;
            ph_ff   <= nxt_ph;
            done_ff <= nxt_done;
            fail_ff <= nxt_fail;
        end
    end

    assign busy      = (ph_ff != 2'd0);
    assign done      = done_ff;
    assign fail      = fail_ff;
    assign mem_we    = (ph_ff == 2'd1);
    assign mem_addr  = adr_ff;
    assign mem_wdata = pat;
endmodule : nst_memtest
`default_nettype wire

// [src/nst_self_test.sv]
// self-test sequencer of a network communications module
`timescale 1ns/1ps
`default_nettype none
`include "nst_consts.svh"
// Behaviour
// - diagnostics command first takes module offline, then starts the sequence
// - indicator lit at start; turned off only when result is success
// - program checksum against stored value; mismatch gives code 01, skip to end
// - commanded run tests transmit/receive memory with four patterns; code 02
// - station address read and validated; invalid gives code 03
// - internal loopback packet test; failure 04, else 00
// - after commanded pass, module reinitialises before indicator update
// - result code shown in status register at end of either sequence
// - power-up sequence runs on power-on, reset, and reset command 77
// - power-up run tests working RAM with four patterns; code 02
// - power-up run initialises variables after address check, before loopback
// - result returned only when hardware is healthy enough
// - loopback frames never go to network; commands during a run are ignored
module nst_self_test
    import nst_pkg::*;
#(
    parameter int AW = 4
)(
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          cmd_valid,
    input  wire logic [7:0]    cmd_code,
    output logic               busy,
    output logic               led_fail,
    output logic [7:0]         status_reg,
    output logic               status_valid,
    output logic               go_offline,
    output logic               online,
    output logic               net_tx_enable,
    output logic               loopback_en,
    output logic               init_pulse,
    output logic               chk_start,
    input  wire logic          chk_done,
    input  wire logic [15:0]   chk_sum,
    input  wire logic [15:0]   chk_stored,
    input  wire logic [47:0]   station_addr,
    output logic               loop_start,
    input  wire logic          loop_done,
    input  wire logic          loop_ok,
    output logic               mem_sel,
    output logic               mem_we,
    output logic [AW-1:0]      mem_addr,
    output logic [7:0]         mem_wdata,
    input  wire logic [7:0]    mem_rdata
);
    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    nst_state_e state_ff, nxt_state;
    logic       diag_ff, nxt_diag;      // commanded run vs power-up run
    logic [7:0] res_ff, nxt_res;
    logic [7:0] stat_ff, nxt_stat;
    logic       sval_ff, nxt_sval;
    logic       led_ff, nxt_led;
    logic       onl_ff, nxt_onl;
    logic       mt_start, mt_done, mt_fail;
    logic       addr_ok;

    // broadcast/group bit set or all-zero address is not a station address
    assign addr_ok = !station_addr[40] && (station_addr != '0);

    nst_memtest #(.AW(AW)) u_mem (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .start     (mt_start),
        .busy      (),
        .done      (mt_done),
        .fail      (mt_fail),
        .mem_we    (mem_we),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata)
    );

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_diag   = diag_ff;
        nxt_res    = res_ff;
        nxt_stat   = stat_ff;
        nxt_sval   = sval_ff;
        nxt_led    = led_ff;
        nxt_onl    = onl_ff;
        mt_start   = 1'b0;
        chk_start  = 1'b0;
        loop_start = 1'b0;
        init_pulse = 1'b0;
        go_offline = 1'b0;
        unique case (state_ff)
            NST_IDLE:
            begin
                // commands during a run are ignored; host waits for result
                if (cmd_valid && cmd_code == `NST_CMD_DIAG)
                begin
                    nxt_diag  = 1'b1;
                    nxt_sval  = 1'b0;
                    nxt_state = NST_OFFLINE;
                end
                else if (cmd_valid && cmd_code == `NST_CMD_RESET)
                begin
                    nxt_diag  = 1'b0;
                    nxt_sval  = 1'b0;
                    nxt_led   = 1'b1;
                    nxt_state = NST_CHKSUM;
                end
            end
            NST_OFFLINE:
            begin
                go_offline = 1'b1;
                nxt_onl    = 1'b0;
                nxt_led    = 1'b1;
                nxt_state  = NST_CHKSUM;
            end
            NST_CHKSUM:
            begin
                chk_start = 1'b1;
                nxt_state = NST_CHKWAIT;
            end
            NST_CHKWAIT:
                if (chk_done)
                begin
                    if (chk_sum != chk_stored)
                    begin
                        nxt_res   = `NST_RES_CHKSUM;
                        nxt_state = NST_LED;
                    end
                    else
                        nxt_state = NST_MEMWR;
                end
            NST_MEMWR:
            begin
                mt_start  = 1'b1;
                nxt_state = NST_MEMRD;
            end
            NST_MEMRD:
                if (mt_done)
                begin
                    if (mt_fail)
                    begin
                        nxt_res   = `NST_RES_MEM;
                        nxt_state = NST_LED;
                    end
                    else
                        nxt_state = NST_ADDR;
                end
            NST_ADDR:
                if (!addr_ok)
                begin
                    nxt_res   = `NST_RES_ADDR;
                    nxt_state = NST_LED;
                end
                else
                    nxt_state = diag_ff ? NST_LOOP : NST_INIT;
            NST_INIT:
            begin
                init_pulse = 1'b1;
                nxt_state  = NST_LOOP;
            end
            NST_LOOP:
            begin
                loop_start = 1'b1;
                nxt_state  = NST_LOOPW;
            end
            NST_LOOPW:
                if (loop_done)
                begin
                    nxt_res   = loop_ok ? `NST_RES_PASS : `NST_RES_LOOP;
                    nxt_state = (loop_ok && diag_ff) ? NST_BRDRST : NST_LED;
                end
            NST_BRDRST:
            begin
                init_pulse = 1'b1;
                nxt_state  = NST_LED;
            end
            NST_LED:
            begin
                if (res_ff == `NST_RES_PASS)
                    nxt_led = 1'b0;
                nxt_state = NST_REPORT;
            end
            NST_REPORT:
            begin
                nxt_stat  = res_ff;
                nxt_sval  = 1'b1;
                nxt_state = NST_IDLE;
            end
            default: nxt_state = NST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= NST_CHKSUM;
            diag_ff  <= 1'b0;
            res_ff   <= `NST_RES_RST;
            stat_ff  <= `NST_RES_RST;
            sval_ff  <= 1'b0;
            led_ff   <= 1'b1;
            onl_ff   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            diag_ff  <= nxt_diag;
            res_ff   <= nxt_res;
            stat_ff  <= nxt_stat;
            sval_ff  <= nxt_sval;
            led_ff   <= nxt_led;
            onl_ff   <= nxt_onl;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign busy          = (state_ff != NST_IDLE);
    assign led_fail      = led_ff;
    assign status_reg    = stat_ff;
    assign status_valid  = sval_ff;
    assign online        = onl_ff;
    // transmitter gated while test runs so test frames stay internal
    assign net_tx_enable = onl_ff && !busy;
    assign loopback_en   = (state_ff == NST_LOOP) || (state_ff == NST_LOOPW);
    assign mem_sel       = diag_ff; // 0 working ram, 1 tx/rx buffer
endmodule : nst_self_test
`default_nettype wire

// [dv/nst_env_model.sv]
// model of the memories, checksum engine and loopback engine
`timescale 1ns/1ps
`default_nettype none
module nst_env_model (
    input  wire logic       clk_sys,
    input  wire logic       chk_start,
    input  wire logic       loop_start,
    input  wire logic       mem_we,
    input  wire logic [3:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    input  wire logic       mem_bad,
    input  wire logic       loop_pass,
    input  wire logic [3:0] lat,
    output logic            chk_done,
    output logic            loop_done,
    output logic            loop_ok,
    output logic [7:0]      mem_rdata
);
    logic [7:0] ram [16];
    int         chk_cnt = 0;
    int         loop_cnt = 0;
    // faulty memory: bit 0 reads back inverted
    assign mem_rdata = ram[mem_addr] ^ {7'h00, mem_bad};
    always @(posedge clk_sys)
    begin
        if (mem_we)
            ram[mem_addr] <= mem_wdata;
        chk_cnt <= chk_start ? lat + 1 : (chk_cnt > 0 ? chk_cnt - 1 : 0);
        loop_cnt <= loop_start ? lat + 3 : (loop_cnt > 0 ? loop_cnt - 1 : 0);
    end
    assign chk_done = (chk_cnt == 1);
    assign loop_done = (loop_cnt == 1);
    // outside loop_done the ok line toggles, so a stale sample shows
    assign loop_ok = loop_done ? loop_pass : loop_cnt[0];
endmodule : nst_env_model
`default_nettype wire

// [dv/nst_self_test_asserts.sv]
// concurrent checks on the ports of the self-test sequencer
`timescale 1ns/1ps
`default_nettype none
module nst_self_test_asserts (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic       busy,
    input wire logic       led_fail,
    input wire logic [7:0] status_reg,
    input wire logic       status_valid,
    input wire logic       go_offline,
    input wire logic       net_tx_enable,
    input wire logic       loopback_en,
    input wire logic       chk_start,
    input wire logic       online,
    input wire logic       loop_start
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_diag_offline: assert property (cmd_valid && !busy && cmd_code == 8'h12 |=> go_offline)
        else $error("no go offline after diagnostics command");
    a_offline_first: assert property (go_offline |=> chk_start)
        else $error("checksum not started after going offline");
    a_reset_cmd: assert property (cmd_valid && !busy && cmd_code == 8'h77 |-> ##[1:2] chk_start)
        else $error("reset command did not start the sequence");
    a_led_lit: assert property (chk_start |-> ##[0:1] led_fail)
        else $error("indicator dark at sequence start");
    a_led_pass: assert property ($rose(status_valid) && status_reg == 8'h00 |-> !led_fail)
        else $error("indicator lit after success");
    a_led_fail: assert property ($rose(status_valid) && status_reg != 8'h00 |-> led_fail)
        else $error("indicator dark after failure");
    a_no_tx_loop: assert property (loopback_en |-> !net_tx_enable)
        else $error("network transmit enabled in loopback");
    a_status_hold: assert property (status_valid && !cmd_valid |=> status_valid && $stable(status_reg))
        else $error("reported result did not stand");
    a_loop_internal: assert property (loop_start |-> loopback_en && !net_tx_enable)
        else $error("loopback step not kept internal");
    a_offline_kept: assert property (go_offline |=> !online && busy)
        else $error("module still online after going offline");
endmodule : nst_self_test_asserts
bind nst_self_test nst_self_test_asserts nst_self_test_asserts_i (
    .clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .busy(busy), .led_fail(led_fail), .status_reg(status_reg), .status_valid(status_valid),
    .go_offline(go_offline), .net_tx_enable(net_tx_enable), .loopback_en(loopback_en),
    .chk_start(chk_start), .online(online), .loop_start(loop_start));
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench of the self-test sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_sys = 0, rstn = 0, cmd_valid = 0, mem_bad = 0, loop_pass = 1;
    logic [7:0]  cmd_code = 8'h00, status_reg, mem_wdata, mem_rdata;
    logic [15:0] chk_sum = 16'h1234, chk_stored = 16'h1234;
    logic [47:0] station_addr = 48'h0000_0000_0001;
    logic [3:0]  lat = 4'h7, mem_addr;
    logic        busy, led_fail, status_valid, go_offline, init_pulse, chk_start, chk_done;
    logic        loop_start, loop_done, loop_ok, mem_sel, mem_we;
    logic        seen_off, seen_loop, seen_init, init_late, sel_seen;
    int          fail_count = 0, total_checks = 0;
    nst_self_test #(.AW(4)) nst_self_test_i (
        .clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .busy(busy), .led_fail(led_fail), .status_reg(status_reg),
        .status_valid(status_valid), .go_offline(go_offline), .online(),
        .net_tx_enable(), .loopback_en(), .init_pulse(init_pulse), .chk_start(chk_start),
        .chk_done(chk_done), .chk_sum(chk_sum), .chk_stored(chk_stored),
        .station_addr(station_addr), .loop_start(loop_start), .loop_done(loop_done),
        .loop_ok(loop_ok), .mem_sel(mem_sel), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    nst_env_model nst_env_model_i (
        .clk_sys(clk_sys), .chk_start(chk_start), .loop_start(loop_start), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_bad(mem_bad),
        .loop_pass(loop_pass), .lat(lat), .chk_done(chk_done), .loop_done(loop_done),
        .loop_ok(loop_ok), .mem_rdata(mem_rdata));
    always #50 clk_sys = ~clk_sys;
    // event history of one run
    always @(posedge clk_sys)
    begin
        if (go_offline) seen_off <= 1;
        if (loop_start) seen_loop <= 1;
        if (init_pulse) seen_init <= 1;
        if (init_pulse) init_late <= seen_loop;
        if (mem_we) sel_seen <= mem_sel;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // host waits for the result before its next command
    task automatic run(input logic [7:0] code, input logic [7:0] exp);
        int n;
        @(negedge clk_sys);
        {seen_off, seen_loop, seen_init, init_late, sel_seen} = 5'h00;
        cmd_valid = (code != 8'h00);
        cmd_code = code;
        @(negedge clk_sys);
        cmd_valid = 0;
        n = 0;
        while (status_valid !== 1'b1 && n < 600)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, status_valid}, 8'h01);
        chk(status_reg, exp);
        chk({7'h00, led_fail}, {7'h00, exp != 8'h00});
    endtask : run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_powerup();
        run(8'h00, 8'h00);
        chk({7'h00, init_late}, 8'h00);
        chk({7'h00, sel_seen}, 8'h00);
    endtask : t_powerup
    task automatic t_diag();
        lat = 4'h0;
        run(8'h12, 8'h00);
        chk({7'h00, seen_off}, 8'h01);
        chk({6'h00, seen_init, init_late}, 8'h03);
        chk({7'h00, sel_seen}, 8'h01);
        lat = 4'h7;
    endtask : t_diag
    task automatic t_faults();
        chk_stored = 16'h1235;
        run(8'h12, 8'h01);
        chk({7'h00, seen_loop}, 8'h00);
        chk_stored = 16'h1234;
        run(8'h77, 8'h00);
        mem_bad = 1;
        run(8'h77, 8'h02);
        mem_bad = 0;
        run(8'h77, 8'h00);
        mem_bad = 1;
        run(8'h12, 8'h02);
        mem_bad = 0;
        station_addr = 48'h0100_0000_0000;
        run(8'h77, 8'h03);
        chk({7'h00, seen_init}, 8'h00);
        station_addr = 48'h0000_0000_0000;
        run(8'h77, 8'h03);
        station_addr = 48'h0000_0000_0001;
        run(8'h77, 8'h00);
        loop_pass = 0;
        run(8'h12, 8'h04);
        loop_pass = 1;
        run(8'h77, 8'h00);
    endtask : t_faults
    task automatic t_mid_reset();
        cmd_valid = 1;
        cmd_code = 8'h12;
        @(negedge clk_sys);
        cmd_valid = 0;
        repeat (30) @(negedge clk_sys);
        rstn = 0;
        @(negedge clk_sys);
        chk({6'h00, led_fail, status_valid}, 8'h02);
        rstn = 1;
        run(8'h00, 8'h00);
    endtask : t_mid_reset
    initial
    begin
        #(20000 * 100);
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (12) @(negedge clk_sys);
        rstn = 1;
        t_powerup();
        t_diag();
        t_faults();
        t_mid_reset();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
